// >>> verilog/chan_cal_regs.vh
// Purpose: Register offsets, field positions and reset values of the channel-0 calibration bank
// Assumes: Classic Wishbone, 32-bit data, word index = register address
// Notes: Byte address is four times the word index
`ifndef CHAN_CAL_REGS_VH
`define CHAN_CAL_REGS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_LIMIT_HIGH 6'h07
`define IDX_LIMIT_LOW 6'h08
`define IDX_CHAN0_CONFIG 6'h09
`define IDX_CHAN0_OFFSET_HIGH 6'h0a
`define IDX_CHAN0_OFFSET_LOW 6'h0b
`define IDX_CHAN0_GAIN_HIGH 6'h0c
`define IDX_CHAN0_GAIN_LOW 6'h0d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UPPER_BYTE_HI 15
`define UPPER_BYTE_LO 8
`define SETTING_HI 3
`define SETTING_LO 0
`define DELAY_HI 15
`define DELAY_LO 6
`define DC_OFF_BIT 2
`define INSEL_HI 1
`define INSEL_LO 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_ZERO16 16'h0000
`define RST_GAIN_HIGH 16'h8000
`define RST_ZERO24 24'h000000
`define RST_ZERO10 10'h000
`define RST_ZERO4 4'h0
`define RST_BIT_CLEAR 1'b0
`define RST_BIT_SET 1'b1
`define RST_GAIN_FULL 24'h800000

// ----------------------------------------------------------------
// Writable-bit masks and gain reference
// ----------------------------------------------------------------
`define MASK_FULL 16'hffff
`define MASK_LIMIT_LOW 16'hff0f
`define MASK_CONFIG 16'hffc7
`define MASK_UPPER_BYTE 16'hff00
`define GAIN_UNITY 24'h800000

// ----------------------------------------------------------------
// Input select codes
// ----------------------------------------------------------------
`define INSEL_PINS 2'h0
`define INSEL_SHORTED 2'h1
`define INSEL_TEST_POS 2'h2
`define INSEL_TEST_NEG 2'h3

`endif

// >>> verilog/masked_reg16.v
// Purpose: One 16-bit register with a writable-bit mask and byte enables
// Assumes: Clocked by the system clock, asynchronous active-high reset
// Notes: Bits outside the mask hold zero and read zero

module masked_reg16 #(
    parameter [15:0] RESET_VALUE = 16'h0000,
    parameter [15:0] WRITE_MASK = 16'hffff
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Write port
    input wire wr_en,
    input wire [1:0] byte_en,
    input wire [15:0] wr_data,
    // Stored value
    output wire [15:0] value
);

    reg [15:0] value_q;
    wire [15:0] lane_mask;

    assign lane_mask = {{8{byte_en[1]}}, {8{byte_en[0]}}} & WRITE_MASK;
    assign value = value_q & WRITE_MASK;

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            value_q <= RESET_VALUE & WRITE_MASK;
        end
        else if (wr_en)
        begin
            value_q <= (value_q & ~lane_mask) | (wr_data & lane_mask);
        end
    end

endmodule // masked_reg16

// >>> verilog/wb_ack_gen.v
// Purpose: Single-cycle acknowledge generator for classic Wishbone
// Assumes: Master drops cyc/stb for one cycle after ack
// Notes: ack rises the cycle after a new request and lasts one cycle

module wb_ack_gen (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Bus request
    input wire req,
    // Acknowledge
    output wire ack,
    output wire take
);

    reg ack_q;

    assign take = req & ~ack_q;
    assign ack = ack_q;

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= take;
        end
    end

endmodule // wb_ack_gen

// >>> verilog/chan_cal_bank.v
// Purpose: Channel-0 configuration and calibration register bank with threshold and filter setting
// Assumes: Classic Wishbone slave, 32-bit data, registers at word index = address
// Notes: Unmapped indices read zero and are acknowledged; writes there are dropped
//
// Implementation choice: register access over Wishbone.
`include "chan_cal_regs.vh"

module chan_cal_bank (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Current-detect threshold and filter setting
    output wire [23:0] current_detect_limit,
    output wire [3:0] dc_removal_setting,
    // Channel 0 controls
    output wire [9:0] chan0_sample_delay,
    output wire chan0_dc_removal_off,
    output wire [1:0] chan0_input_select,
    output wire chan0_dc_removal_active,
    output wire chan0_input_shorted,
    output wire chan0_test_signal_on,
    output wire chan0_test_signal_negative,
    // Channel 0 calibration
    output wire [23:0] chan0_offset,
    output wire [23:0] chan0_gain,
    output wire chan0_gain_unity
);

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    localparam NREG = 7;

    wire req;
    wire take;
    wire [5:0] idx;
    wire [NREG-1:0] hit;
    wire [NREG-1:0] wr_hit;
    wire [15:0] value [0:NREG-1];
    reg [31:0] rd_data_q;
    reg [15:0] rd_mux;
    integer k;

    assign req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[7:2];

    wb_ack_gen ack_gen (
        .clk_sys(clk_sys),
        .rst(rst),
        .req(req),
        .ack(wb_ack_o),
        .take(take)
    );

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    // Index order: limit high, limit low, config, offset high/low, gain high/low
    localparam [6*NREG-1:0] IDX_TABLE = {
        `IDX_CHAN0_GAIN_LOW, `IDX_CHAN0_GAIN_HIGH, `IDX_CHAN0_OFFSET_LOW, `IDX_CHAN0_OFFSET_HIGH,
        `IDX_CHAN0_CONFIG, `IDX_LIMIT_LOW, `IDX_LIMIT_HIGH};
    localparam [16*NREG-1:0] MASK_TABLE = {
        `MASK_UPPER_BYTE, `MASK_FULL, `MASK_UPPER_BYTE, `MASK_FULL,
        `MASK_CONFIG, `MASK_LIMIT_LOW, `MASK_FULL};
    localparam [16*NREG-1:0] RST_TABLE = {
        `RST_ZERO16, `RST_GAIN_HIGH, `RST_ZERO16, `RST_ZERO16,
        `RST_ZERO16, `RST_ZERO16, `RST_ZERO16};

    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1)
        begin : regs
            assign hit[g] = (idx == IDX_TABLE[6*g +: 6]);
            assign wr_hit[g] = take & wb_we_i & hit[g];
            masked_reg16 #(
                .RESET_VALUE(RST_TABLE[16*g +: 16]),
                .WRITE_MASK(MASK_TABLE[16*g +: 16])
            ) store (
                .clk_sys(clk_sys),
                .rst(rst),
                .wr_en(wr_hit[g]),
                .byte_en(wb_sel_i[1:0]),
                .wr_data(wb_dat_i[15:0]),
                .value(value[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always @*
    begin
        rd_mux = 16'h0000;
        for (k = 0; k < NREG; k = k + 1)
        begin
            if (hit[k])
            begin
                rd_mux = value[k];
            end
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rd_data_q <= 32'h00000000;
        end
        else if (take & ~wb_we_i)
        begin
            rd_data_q <= {16'h0000, rd_mux};
        end
    end

    assign wb_dat_o = rd_data_q;

    // ----------------------------------------------------------------
    // Field registers
    // ----------------------------------------------------------------
    // Threshold and filter setting
    reg [23:0] limit_d;
    reg [23:0] limit_q;
    reg [3:0] setting_d;
    reg [3:0] setting_q;
    // Channel 0 configuration
    reg [9:0] delay_d;
    reg [9:0] delay_q;
    reg dc_off_d;
    reg dc_off_q;
    reg dc_active_d;
    reg dc_active_q;
    reg [1:0] insel_d;
    reg [1:0] insel_q;
    reg shorted_d;
    reg shorted_q;
    reg test_on_d;
    reg test_on_q;
    reg test_neg_d;
    reg test_neg_q;
    // Channel 0 calibration
    reg [23:0] offset_d;
    reg [23:0] offset_q;
    reg [23:0] gain_d;
    reg [23:0] gain_q;
    reg unity_d;
    reg unity_q;

    // ----------------------------------------------------------------
    // Threshold next value
    // ----------------------------------------------------------------
    always @*
    begin
        limit_d = {value[0], value[1][`UPPER_BYTE_HI:`UPPER_BYTE_LO]};
        setting_d = value[1][`SETTING_HI:`SETTING_LO];
    end

    // ----------------------------------------------------------------
    // Configuration next value
    // ----------------------------------------------------------------
    always @*
    begin
        delay_d = value[2][`DELAY_HI:`DELAY_LO];
        dc_off_d = value[2][`DC_OFF_BIT];
        dc_active_d = ~value[2][`DC_OFF_BIT];
        insel_d = value[2][`INSEL_HI:`INSEL_LO];
        shorted_d = 1'b0;
        test_on_d = 1'b0;
        test_neg_d = 1'b0;
        case (insel_d)
            `INSEL_PINS:
            begin
                shorted_d = 1'b0;
            end
            `INSEL_SHORTED:
            begin
                shorted_d = 1'b1;
            end
            `INSEL_TEST_POS:
            begin
                test_on_d = 1'b1;
            end
            `INSEL_TEST_NEG:
            begin
                test_on_d = 1'b1;
                test_neg_d = 1'b1;
            end
            default:
            begin
                test_on_d = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Calibration next value
    // ----------------------------------------------------------------
    always @*
    begin
        offset_d = {value[3], value[4][`UPPER_BYTE_HI:`UPPER_BYTE_LO]};
        gain_d = {value[5], value[6][`UPPER_BYTE_HI:`UPPER_BYTE_LO]};
        unity_d = (gain_d == `GAIN_UNITY);
    end

    // ----------------------------------------------------------------
    // Field flops
    // ----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            limit_q <= `RST_ZERO24;
            setting_q <= `RST_ZERO4;
        end
        else
        begin
            limit_q <= limit_d;
            setting_q <= setting_d;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            delay_q <= `RST_ZERO10;
        end
        else
        begin
            delay_q <= delay_d;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            dc_off_q <= `RST_BIT_CLEAR;
        end
        else
        begin
            dc_off_q <= dc_off_d;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            dc_active_q <= `RST_BIT_SET;
        end
        else
        begin
            dc_active_q <= dc_active_d;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            insel_q <= `INSEL_PINS;
        end
        else
        begin
            insel_q <= insel_d;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            shorted_q <= `RST_BIT_CLEAR;
        end
        else
        begin
            shorted_q <= shorted_d;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            test_on_q <= `RST_BIT_CLEAR;
        end
        else
        begin
            test_on_q <= test_on_d;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            test_neg_q <= `RST_BIT_CLEAR;
        end
        else
        begin
            test_neg_q <= test_neg_d;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            offset_q <= `RST_ZERO24;
            gain_q <= `RST_GAIN_FULL;
            unity_q <= `RST_BIT_SET;
        end
        else
        begin
            offset_q <= offset_d;
            gain_q <= gain_d;
            unity_q <= unity_d;
        end
    end

    // ----------------------------------------------------------------
    // Field outputs
    // ----------------------------------------------------------------
    assign current_detect_limit = limit_q;
    assign dc_removal_setting = setting_q;
    assign chan0_sample_delay = delay_q;
    assign chan0_dc_removal_off = dc_off_q;
    assign chan0_dc_removal_active = dc_active_q;
    assign chan0_input_select = insel_q;
    assign chan0_input_shorted = shorted_q;
    assign chan0_test_signal_on = test_on_q;
    assign chan0_test_signal_negative = test_neg_q;
    assign chan0_offset = offset_q;
    assign chan0_gain = gain_q;
    assign chan0_gain_unity = unity_q;

endmodule // chan_cal_bank

// >>> tb/chan_cal_bank_props.sv
// Purpose: Checker for the calibration bank bus and fields
// Assumes: Sees only the bank's top-level ports
// Notes: Field outputs follow a write two cycles after it is taken
module chan_cal_bank_props (
    // Clock, reset and bus
    input logic clk_sys,
    input logic rst,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [7:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic [31:0] wb_dat_o,
    input logic wb_ack_o,
    // Fields
    input logic [23:0] current_detect_limit,
    input logic [3:0] dc_removal_setting,
    input logic [9:0] chan0_sample_delay,
    input logic chan0_dc_removal_off,
    input logic chan0_dc_removal_active,
    input logic [1:0] chan0_input_select,
    input logic chan0_test_signal_negative,
    input logic [23:0] chan0_gain,
    input logic chan0_gain_unity
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [5:0] idx = wb_adr_i[7:2];
    wire wr = req && wb_we_i && wb_sel_i[1:0] == 2'h3;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_ack; req |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack long");
    property p_hi; wb_dat_o[31:16] == 16'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper data set");
    property p_dc; chan0_dc_removal_active != chan0_dc_removal_off; endproperty
    a_dc: assert property (p_dc) else $error("dc flags");
    property p_neg; chan0_test_signal_negative == (chan0_input_select == 2'h3); endproperty
    a_neg: assert property (p_neg) else $error("negative test");
    property p_unity; chan0_gain_unity == (chan0_gain == 24'h800000); endproperty
    a_unity: assert property (p_unity) else $error("unity flag");
    property p_gain; wr && idx == 6'h0c |-> ##2 chan0_gain[23:8] == $past(wb_dat_i[15:0], 2); endproperty
    a_gain: assert property (p_gain) else $error("gain high");
    property p_delay; wr && idx == 6'h09 |-> ##2 chan0_sample_delay == $past(wb_dat_i[15:6], 2); endproperty
    a_delay: assert property (p_delay) else $error("delay");
    property p_limit; wr && idx == 6'h08 |-> ##2 current_detect_limit[7:0] == $past(wb_dat_i[15:8], 2)
        && dc_removal_setting == $past(wb_dat_i[3:0], 2); endproperty
    a_limit: assert property (p_limit) else $error("limit low");
    c_wr: cover property (wr && idx == 6'h0c);
    c_rd: cover property (req && !wb_we_i ##1 wb_ack_o);
    c_neg: cover property (chan0_test_signal_negative);
endmodule // chan_cal_bank_props

bind chan_cal_bank chan_cal_bank_props u_chan_cal_bank_props (
    .clk_sys(clk_sys),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .current_detect_limit(current_detect_limit),
    .dc_removal_setting(dc_removal_setting),
    .chan0_sample_delay(chan0_sample_delay),
    .chan0_dc_removal_off(chan0_dc_removal_off),
    .chan0_dc_removal_active(chan0_dc_removal_active),
    .chan0_input_select(chan0_input_select),
    .chan0_test_signal_negative(chan0_test_signal_negative),
    .chan0_gain(chan0_gain),
    .chan0_gain_unity(chan0_gain_unity)
);

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the calibration bank
// Assumes: Ack comes one cycle after a request is taken
// Notes: Patterns reach every input select code
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wb_ack_o, chan0_dc_removal_off, chan0_dc_removal_active, chan0_input_shorted;
    logic chan0_test_signal_on, chan0_test_signal_negative, chan0_gain_unity;
    logic [23:0] current_detect_limit, chan0_offset, chan0_gain;
    logic [3:0] dc_removal_setting;
    logic [9:0] chan0_sample_delay;
    logic [1:0] chan0_input_select;
    logic [15:0] p;
    int err_count = 0;
    int samples_checked = 0;
    logic [15:0] mask [7] = '{16'hffff, 16'hff0f, 16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00};
    logic [15:0] pats [4] = '{16'hffff, 16'h5a5a, 16'h0001, 16'h0000};
    chan_cal_bank u_chan_cal_bank (
        .clk_sys(clk_sys),
        .rst(rst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .current_detect_limit(current_detect_limit),
        .dc_removal_setting(dc_removal_setting),
        .chan0_sample_delay(chan0_sample_delay),
        .chan0_dc_removal_off(chan0_dc_removal_off),
        .chan0_input_select(chan0_input_select),
        .chan0_dc_removal_active(chan0_dc_removal_active),
        .chan0_input_shorted(chan0_input_shorted),
        .chan0_test_signal_on(chan0_test_signal_on),
        .chan0_test_signal_negative(chan0_test_signal_negative),
        .chan0_offset(chan0_offset),
        .chan0_gain(chan0_gain),
        .chan0_gain_unity(chan0_gain_unity)
    );
    always #4 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [5:0] i, input logic [3:0] s, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {i, 2'b00};
        wb_sel_i <= s;
        wb_dat_i <= {16'h0, d};
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 16);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 16)
        begin
            err_count++;
            $display("[FAIL] %0t no ack", $time);
            tally_and_finish();
        end
    endtask
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        for (int k = 0; k < 7; k++)
        begin
            xfer(1'b0, 6'h07 + 6'(k), 4'h3, 16'h0);
            chk(q, (k == 5) ? 32'h8000 : 32'h0);
        end
        chk({chan0_gain_unity, chan0_dc_removal_active, chan0_gain}, {2'b11, 24'h800000});
        foreach (pats[j])
        begin
            p = pats[j];
            for (int k = 0; k < 7; k++)
                xfer(1'b1, 6'h07 + 6'(k), 4'h3, p);
            for (int k = 0; k < 7; k++)
            begin
                xfer(1'b0, 6'h07 + 6'(k), 4'h3, 16'h0);
                chk(q, {16'h0, p & mask[k]});
            end
            chk({current_detect_limit, dc_removal_setting}, {p, p[15:8], p[3:0]});
            chk({chan0_sample_delay, chan0_dc_removal_off, chan0_dc_removal_active}, {p[15:6], p[2], !p[2]});
            chk({chan0_input_select, chan0_input_shorted}, {p[1:0], p[1:0] == 2'h1});
            chk({chan0_test_signal_on, chan0_test_signal_negative}, {p[1], &p[1:0]});
            chk(chan0_offset, {p, p[15:8]});
            chk(chan0_gain, {p, p[15:8]});
        end
        xfer(1'b1, 6'h0c, 4'h1, 16'h1234);
        xfer(1'b0, 6'h0c, 4'h3, 16'h0);
        chk(q, 32'h0034);
        xfer(1'b1, 6'h3f, 4'h3, 16'hffff);
        xfer(1'b0, 6'h3f, 4'h3, 16'h0);
        chk(q, 32'h0);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        xfer(1'b0, 6'h0c, 4'h3, 16'h0);
        chk(q, 32'h8000);
        chk({chan0_gain_unity, chan0_gain}, {1'b1, 24'h800000});
        tally_and_finish();
    end
endmodule // testbench
